//--- rtl/seg_xlate_defines.vh
// constants for the segment translation block: modes, selector fields,
// descriptor layout and table geometry.
// assumes plain verilog-2005; included by bare name, definitions only.
`ifndef SEG_XLATE_DEFINES_VH
`define SEG_XLATE_DEFINES_VH

// operating modes
`define MODE_REAL      2'h0
`define MODE_V86       2'h1
`define MODE_PROT      2'h2

// selector fields
`define SEL_RPL_HI     1
`define SEL_RPL_LO     0
`define SEL_TBL_BIT    2
`define SEL_IDX_HI     15
`define SEL_IDX_LO     3
`define IDX_W          13

// privilege extremes
`define RPL_MOST       2'h0
`define RPL_LEAST      2'h3

// table geometry
`define TBL_ENTRIES    14'h2000
`define DESC_SHIFT     3
`define TBL_MAX_LIMIT  16'hffff

// real mode address formation
`define REAL_SHIFT     4
`define REAL_SUM_W     20
`define REAL_PAD_W     12

// descriptor kinds
`define KIND_CODE      2'h0
`define KIND_DATA      2'h1
`define KIND_STACK     2'h2
`define KIND_LOCAL     2'h3

// descriptor load fsm
`define ST_IDLE        2'h0
`define ST_FETCH       2'h1

// store operand select
`define STORE_GLOBAL   1'h0
`define STORE_LOCAL    1'h1

// reset values
`define SEL_RST        16'h0000
`define BASE_RST       32'h0000_0000
`define SEG_LIMIT_RST  20'h0ffff
`define ATTR_RST       8'h00
`define LIMIT_OUT_RST  20'h00000
`endif

//--- rtl/segment_address_translate.v
// segment address translation: logical to linear/physical address.
// assumes a pipeline that presents loads and translations as one-cycle
// strobes, and a memory side that returns descriptor bases on request.
`timescale 1ns/100ps
`include "seg_xlate_defines.vh"

module segment_address_translate #(
  parameter NSEG = 6                     // number of segment registers
)(
  input  wire        ref_clk,            // core clock
  input  wire        nrst,               // async reset, active low
  input  wire [1:0]  mode,               // real, v86 or protected
  input  wire        paging_en,          // paging unit enabled
  // segment register load
  input  wire        seg_load,           // load strobe
  input  wire [2:0]  seg_load_num,       // which segment register
  input  wire [15:0] seg_load_sel,       // new selector value
  // descriptor fetch toward memory
  output reg         desc_req,           // descriptor read request
  output reg  [31:0] desc_addr,          // linear address of entry
  input  wire        desc_ack,           // descriptor returned
  input  wire [31:0] desc_base,          // descriptor base field
  input  wire [19:0] desc_limit,         // descriptor limit field
  input  wire [1:0]  desc_kind,          // code, data, stack, local
  input  wire [7:0]  desc_attr,          // attribute byte
  // translation request
  input  wire        xl_req,             // translate strobe
  input  wire [2:0]  xl_seg,             // segment register used
  input  wire [31:0] xl_offset,          // instruction offset
  output wire        xl_ready,           // not busy with a load
  output reg         xl_valid,           // result pulse
  output reg  [31:0] xl_addr,            // linear or physical address
  output reg         xl_to_paging,       // result must go to paging
  output reg         xl_null_fault,      // null global selector used in protected mode
  output reg  [1:0]  xl_rpl,             // selector privilege in protected mode, else level 0
  output reg         xl_most_priv,       // rpl is level 0
  // table pointer instructions
  input  wire        load_global_pointer,
  input  wire [31:0] gp_base_in,         // linear base operand
  input  wire [15:0] gp_limit_in,        // limit operand
  input  wire        load_local_selector,
  input  wire [15:0] local_sel_in,       // local selector operand
  input  wire        load_interrupt_table_pointer,
  input  wire [31:0] ip_base_in,         // linear base operand
  input  wire [15:0] ip_limit_in,        // limit operand
  input  wire        store_global_pointer,
  input  wire        store_local_selector,
  output reg         store_valid,        // store data pulse
  output reg  [47:0] store_data,         // image to write to memory
  // table pointer state
  output reg  [31:0] global_base_r,      // global table base
  output reg  [15:0] global_limit_r,     // global table limit
  output reg  [15:0] local_table_selector_reg_r,
  output reg  [31:0] local_base_r,       // local table base
  output reg  [31:0] int_base_r,         // interrupt table base
  output reg  [15:0] int_limit_r,        // interrupt table limit
  output reg  [1:0]  seg_kind_out,       // kind of last used segment
  output reg  [19:0] seg_limit_out,      // limit of last used segment
  output reg  [7:0]  seg_attr_out        // attr of last used segment
);

  // ==========================================================
  // selector decode helpers
  // ==========================================================
  // field picks used by load path and translation path
  function [1:0] requested_privilege_level;
    input [15:0] sel;
    begin
      requested_privilege_level = sel[`SEL_RPL_HI:`SEL_RPL_LO];
    end
  endfunction

  function table_select_bit;
    input [15:0] sel;
    begin
      table_select_bit = sel[`SEL_TBL_BIT];
    end
  endfunction

  function [`IDX_W-1:0] sel_index;
    input [15:0] sel;
    begin
      sel_index = sel[`SEL_IDX_HI:`SEL_IDX_LO];
    end
  endfunction

  // null means global table, index zero
  function is_null_global;
    input [15:0] sel;
    begin
      is_null_global = (table_select_bit(sel) == 1'b0) &&
                       (sel_index(sel) == {`IDX_W{1'b0}});
    end
  endfunction

  // ==========================================================
  // segment cache storage
  // ==========================================================
  reg [15:0] seg_sel_r   [0:NSEG-1];   // cached selectors
  reg [31:0] seg_base_r  [0:NSEG-1];   // cached descriptor bases
  reg [19:0] seg_limit_r [0:NSEG-1];   // cached limits
  reg [1:0]  seg_kind_r  [0:NSEG-1];   // cached segment kinds
  reg [7:0]  seg_attr_r  [0:NSEG-1];   // cached attributes

  reg [1:0]  state_r;                  // load fsm state
  reg [2:0]  pend_num_r;               // segment being loaded
  reg        pend_local_r;             // loading the local table

  // translation waits while any descriptor fetch is open, so no
  // access can see a stale base after a selector load
  assign xl_ready = (state_r == `ST_IDLE);

  // ==========================================================
  // descriptor address: table base plus index times eight
  // ==========================================================
  reg [31:0] fetch_addr;               // entry address for a load
  reg [31:0] tbl_base;                 // chosen table base
  reg [15:0] fetch_sel;                // selector being fetched
  always @*
  begin
    fetch_sel = load_local_selector ? local_sel_in : seg_load_sel;
    // local selector always points into the global table
    if (load_local_selector)
      tbl_base = global_base_r;
    else if (table_select_bit(fetch_sel))
      tbl_base = local_base_r;
    else
      tbl_base = global_base_r;
    // entry is eight bytes; index spans 8192 entries, 64 KB
    fetch_addr = tbl_base +
      {16'h0000, sel_index(fetch_sel), {`DESC_SHIFT{1'b0}}};
  end

  // ==========================================================
  // load fsm and table pointer registers
  // ==========================================================
  // only protected mode segment loads and local selector loads (in any mode) fetch
  // descriptors; real and v86 segment loads derive the base straight from the selector
  integer i;
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r                    <= `ST_IDLE;
      pend_num_r                 <= 3'h0;
      pend_local_r               <= 1'b0;
      desc_req                   <= 1'b0;
      desc_addr                  <= `BASE_RST;
      global_base_r              <= `BASE_RST;
      global_limit_r             <= `TBL_MAX_LIMIT;
      local_table_selector_reg_r <= `SEL_RST;
      local_base_r               <= `BASE_RST;
      int_base_r                 <= `BASE_RST;
      int_limit_r                <= `TBL_MAX_LIMIT;
      for (i = 0; i < NSEG; i = i + 1)
      begin
        seg_sel_r[i]   <= `SEL_RST;
        seg_base_r[i]  <= `BASE_RST;
        seg_limit_r[i] <= `SEG_LIMIT_RST;
        seg_kind_r[i]  <= `KIND_DATA;
        seg_attr_r[i]  <= `ATTR_RST;
      end
    end
    else
    begin
      // pointer loads take linear operands, usable from real mode
      if (load_global_pointer)
      begin
        global_base_r  <= gp_base_in;
        global_limit_r <= gp_limit_in;
      end
      // interrupt pointer is only held here; lookups live elsewhere
      if (load_interrupt_table_pointer)
      begin
        int_base_r  <= ip_base_in;
        int_limit_r <= ip_limit_in;
      end
      case (state_r)
        `ST_IDLE:
        begin
          // a local selector load wins over a segment load in the same
          // cycle; the pipeline must not issue both at once
          if (load_local_selector)
          begin
            local_table_selector_reg_r <= local_sel_in;
            pend_local_r <= 1'b1;
            if (is_null_global(local_sel_in))
              local_base_r <= `BASE_RST;
            else
            begin
              desc_req  <= 1'b1;
              desc_addr <= fetch_addr;
              state_r   <= `ST_FETCH;
            end
          end
          else if (seg_load && seg_load_num < NSEG)
          begin
            seg_sel_r[seg_load_num] <= seg_load_sel;
            pend_num_r   <= seg_load_num;
            pend_local_r <= 1'b0;
            if (mode != `MODE_PROT)
              // real and v86 base is selector shifted by four
              seg_base_r[seg_load_num] <=
                {{`REAL_PAD_W{1'b0}}, seg_load_sel,
                 {`REAL_SHIFT{1'b0}}};
            else if (is_null_global(seg_load_sel))
              seg_base_r[seg_load_num] <= `BASE_RST;
            else
            begin
              desc_req  <= 1'b1;
              desc_addr <= fetch_addr;
              state_r   <= `ST_FETCH;
            end
          end
        end
        `ST_FETCH:
        begin
          if (desc_ack)
          begin
            desc_req <= 1'b0;
            state_r  <= `ST_IDLE;
            if (pend_local_r)
              local_base_r <= desc_base;
            else
            begin
              // descriptor supplies base, limit, attributes, kind
              seg_base_r[pend_num_r]  <= desc_base;
              seg_limit_r[pend_num_r] <= desc_limit;
              seg_kind_r[pend_num_r]  <= desc_kind;
              seg_attr_r[pend_num_r]  <= desc_attr;
            end
          end
        end
        default:
          state_r <= `ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // address formation
  // ==========================================================
  // one cycle from request to result; protected mode uses the cached
  // base and never rereads the table
  reg [15:0] cur_sel;                  // selector of requested segment
  reg [`REAL_SUM_W-1:0] real_sum;      // 20-bit real-mode sum
  reg [31:0] addr_nxt;                 // formed address
  always @*
  begin
    cur_sel  = seg_sel_r[xl_seg];
    // 16-bit segment times 16 plus 16-bit offset; carry past bit 19
    // wraps, which keeps the result inside the first megabyte
    real_sum = {cur_sel, {`REAL_SHIFT{1'b0}}} +
               {{`REAL_SHIFT{1'b0}}, xl_offset[15:0]};
    if (mode == `MODE_PROT)
      addr_nxt = seg_base_r[xl_seg] + xl_offset;
    else
      addr_nxt = {{`REAL_PAD_W{1'b0}}, real_sum};
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      xl_valid      <= 1'b0;
      xl_addr       <= `BASE_RST;
      xl_to_paging  <= 1'b0;
      xl_null_fault <= 1'b0;
      xl_rpl        <= `RPL_MOST;
      xl_most_priv  <= 1'b1;
      seg_kind_out  <= `KIND_DATA;
      seg_limit_out <= `LIMIT_OUT_RST;
      seg_attr_out  <= `ATTR_RST;
    end
    else
    begin
      // requests naming a missing segment register get no answer
      xl_valid <= xl_req && xl_ready && (xl_seg < NSEG);
      if (xl_req && xl_ready && xl_seg < NSEG)
      begin
        xl_addr <= addr_nxt;
        // real mode output is physical; v86 and protected go to paging when paging_en is set
        xl_to_paging  <= paging_en && (mode != `MODE_REAL);
        xl_null_fault <= (mode == `MODE_PROT) &&
                         is_null_global(cur_sel);
        // real mode behaves as most privileged
        xl_rpl <= (mode == `MODE_PROT) ?
                  requested_privilege_level(cur_sel) : `RPL_MOST;
        xl_most_priv <= (mode != `MODE_PROT) ||
          (requested_privilege_level(cur_sel) == `RPL_MOST);
        seg_kind_out  <= seg_kind_r[xl_seg];
        seg_limit_out <= seg_limit_r[xl_seg];
        seg_attr_out  <= seg_attr_r[xl_seg];
      end
    end
  end

  // ==========================================================
  // store instructions
  // ==========================================================
  // global image: limit in low word, base above; local: selector only
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      store_valid <= 1'b0;
      store_data  <= 48'h0000_0000_0000;
    end
    else
    begin
      // global image wins when both stores are strobed together
      store_valid <= store_global_pointer | store_local_selector;
      if (store_global_pointer)
        store_data <= {global_base_r, global_limit_r};
      else if (store_local_selector)
        store_data <= {32'h0000_0000,
                       local_table_selector_reg_r};
    end
  end

endmodule

//--- bench/seg_xlate_properties.sv
// checker for segment translation: timing and value relations at ports.
// assumes binding to the top module; sees only its ports.
`timescale 1ns/100ps
`include "seg_xlate_defines.vh"
module seg_xlate_properties(
  input wire        ref_clk,
  input wire        nrst,
  input wire [1:0]  mode,
  input wire        paging_en,
  input wire        xl_req,
  input wire        xl_ready,
  input wire [2:0]  xl_seg,
  input wire        xl_valid,
  input wire [31:0] xl_addr,
  input wire        xl_to_paging,
  input wire [1:0]  xl_rpl,
  input wire        xl_most_priv,
  input wire        desc_req,
  input wire        desc_ack,
  input wire [31:0] desc_addr,
  input wire        load_global_pointer,
  input wire [31:0] gp_base_in,
  input wire        load_local_selector,
  input wire [15:0] local_sel_in,
  input wire [31:0] global_base_r,
  input wire [15:0] global_limit_r,
  input wire [15:0] local_table_selector_reg_r,
  input wire        store_global_pointer,
  input wire        store_local_selector,
  input wire        store_valid,
  input wire [47:0] store_data
);
// =====
// rules
wire [12:0] ldt_idx = local_sel_in[15:3]; // index of local selector
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!nrst);
property p_real_top;
  xl_valid && $past(mode) == `MODE_REAL |-> xl_addr[31:20] == 12'h0;
endproperty
a_real_top: assert property (p_real_top)
  else $error("real address above one megabyte");
property p_answer;
  xl_req && xl_ready && xl_seg < 3'h6 |=> xl_valid;
endproperty
a_answer: assert property (p_answer)
  else $error("translate not answered");
property p_refuse;
  xl_req && !xl_ready |=> !xl_valid;
endproperty
a_refuse: assert property (p_refuse)
  else $error("translate answered while fetching");
property p_paging;
  xl_valid |-> xl_to_paging ==
    ($past(paging_en) && $past(mode) != `MODE_REAL);
endproperty
a_paging: assert property (p_paging)
  else $error("paging forward wrong");
property p_priv;
  xl_valid |-> xl_most_priv == (xl_rpl == `RPL_MOST);
endproperty
a_priv: assert property (p_priv)
  else $error("privilege flag wrong");
property p_hold;
  desc_req && !desc_ack |=> desc_req && $stable(desc_addr);
endproperty
a_hold: assert property (p_hold)
  else $error("fetch dropped early");
property p_busy;
  desc_req |-> !xl_ready;
endproperty
a_busy: assert property (p_busy)
  else $error("ready during fetch");
property p_ldt_fetch;
  load_local_selector && !desc_req &&
    (local_sel_in[2] || ldt_idx != 13'h0) |=> desc_req &&
    desc_addr == $past(global_base_r) + {16'h0, $past(ldt_idx), 3'h0};
endproperty
a_ldt_fetch: assert property (p_ldt_fetch)
  else $error("local selector fetch address wrong");
property p_gp_load;
  load_global_pointer |=> global_base_r == $past(gp_base_in);
endproperty
a_gp_load: assert property (p_gp_load)
  else $error("global base not loaded");
property p_store_g;
  store_global_pointer && !load_global_pointer |=> store_valid &&
    store_data == {$past(global_base_r), $past(global_limit_r)};
endproperty
a_store_g: assert property (p_store_g)
  else $error("global store image wrong");
c_fetch: cover property (desc_req ##1 desc_ack);
c_real: cover property (xl_valid && xl_addr[31:20] == 12'h0);
c_store: cover property (store_valid);
endmodule
bind segment_address_translate seg_xlate_properties
  i_seg_xlate_properties(.*);

//--- bench/desc_mem_model.sv
// memory side model: answers descriptor reads after a set stall.
// assumes request held until the ack pulse is taken.
`timescale 1ns/100ps
module desc_mem_model(
  input wire        ref_clk,
  input wire        nrst,
  input wire        desc_req,
  input wire [31:0] desc_addr,
  input wire [3:0]  stall,
  output reg        desc_ack,
  output reg [31:0] desc_base,
  output reg [19:0] desc_limit,
  output reg [1:0]  desc_kind,
  output reg [7:0]  desc_attr
);
reg [3:0] cnt; // cycles waited
// =====
// answer, else scramble the fields so stale data never matches
always @(posedge ref_clk or negedge nrst)
  if (!nrst)
  begin
    desc_ack <= 1'b0;
    cnt <= 4'h0;
    {desc_base, desc_limit, desc_kind, desc_attr} <= 62'h0;
  end
  else if (desc_req && !desc_ack && cnt >= stall)
  begin
    desc_ack <= 1'b1;
    desc_base <= {desc_addr[15:0], 16'h0008};
    desc_limit <= 20'hfffff;
    desc_kind <= desc_addr[4:3];
    desc_attr <= desc_addr[7:0];
  end
  else
  begin
    desc_ack <= 1'b0;
    cnt <= (desc_req && !desc_ack) ? cnt + 4'h1 : 4'h0;
    {desc_base, desc_limit, desc_kind, desc_attr} <=
      ~{desc_base, desc_limit, desc_kind, desc_attr};
  end
endmodule

//--- bench/segment_address_translate_tb.sv
// testbench for segment translation: directed scenarios.
// assumes the memory model answers fetches; checker bound separately.
`timescale 1ns/100ps
module segment_address_translate_tb;
reg ref_clk = 0, nrst = 0, paging_en = 0, seg_load = 0, xl_req = 0;
reg load_global_pointer = 0, load_local_selector = 0;
reg store_global_pointer = 0, store_local_selector = 0;
reg load_interrupt_table_pointer = 0;
reg [1:0]  mode = 0;
reg [2:0]  seg_load_num = 0, xl_seg = 0;
reg [3:0]  stall = 0;
reg [15:0] seg_load_sel = 0, gp_limit_in = 0, local_sel_in = 0;
reg [15:0] ip_limit_in = 0;
reg [31:0] xl_offset = 0, gp_base_in = 0, ip_base_in = 0, fa;
wire desc_req, desc_ack, xl_ready, xl_valid, xl_to_paging, store_valid;
wire xl_null_fault, xl_most_priv;
wire [31:0] desc_addr, desc_base, xl_addr, global_base_r, local_base_r;
wire [31:0] int_base_r;
wire [19:0] desc_limit, seg_limit_out;
wire [1:0]  desc_kind, xl_rpl, seg_kind_out;
wire [7:0]  desc_attr, seg_attr_out;
wire [15:0] global_limit_r, local_table_selector_reg_r, int_limit_r;
wire [47:0] store_data;
integer miscompares = 0, checks_done = 0, cyc = 0;
segment_address_translate i_segment_address_translate(.*);
desc_mem_model i_desc_mem_model(.*);
// =====
// clock, hang guard, helpers
always #50 ref_clk = ~ref_clk;
always @(posedge ref_clk)
begin
  cyc = cyc + 1;
  if (cyc == 3000)
  begin
    miscompares = miscompares + 1;
    wrap_up;
  end
end
task wrap_up;
begin
  $display("checks %0d miscompares %0d", checks_done, miscompares);
  if (miscompares == 0 && checks_done > 0)
    $display("*** PASS ***");
  else
    $display("*** FAIL ***");
  $finish;
end
endtask
task chk(input [47:0] g, input [47:0] e);
begin
  checks_done = checks_done + 1;
  if (g !== e)
  begin
    miscompares = miscompares + 1;
    $display("ERROR %0t got %h exp %h", $time, g, e);
  end
end
endtask
task tick;
begin
  @(posedge ref_clk);
  #10;
end
endtask
// same formula the memory model uses for a descriptor base
function [31:0] db(input [31:0] a);
  db = {a[15:0], 16'h0008};
endfunction
// segment or local selector load; fa keeps the fetch address seen
task ld(input [2:0] n, input [15:0] s, input loc, input poke);
  integer k;
begin
  tick; // keep strobes of back-to-back calls apart
  seg_load = !loc;
  load_local_selector = loc;
  seg_load_num = n;
  seg_load_sel = s;
  local_sel_in = s;
  tick;
  seg_load = 0;
  load_local_selector = 0;
  fa = 32'hffff_ffff;
  for (k = 0; k < 20 && xl_ready !== 1'b1; k = k + 1)
  begin
    fa = desc_addr;
    xl_req = poke && k == 0; // request while busy is dropped
    if (poke && k == 1)
      chk(xl_valid, 0);
    tick;
  end
  xl_req = 0;
end
endtask
task xl(input [2:0] n, input [31:0] off, input [31:0] ea, input [1:0] rp);
begin
  tick; // keep strobes of back-to-back calls apart
  xl_req = 1;
  xl_seg = n;
  xl_offset = off;
  tick;
  xl_req = 0;
  chk(xl_valid, 1);
  chk(xl_addr, ea);
  chk(xl_rpl, rp);
  chk(xl_to_paging, paging_en && mode != 2'h0);
end
endtask
// =====
// scenarios
task t_real;
begin
  paging_en = 1;
  ld(0, 16'h1234, 0, 0);
  xl(0, 32'habcd_0005, 32'h0001_2345, 0);
  ld(1, 16'hffff, 0, 0);
  xl(1, 32'h0000_0010, 32'h0, 0);
  mode = 1;
  ld(2, 16'h8000, 0, 0);
  xl(2, 32'h0000_ffff, 32'h0008_ffff, 0);
end
endtask
task t_prot;
begin
  mode = 0;
  load_global_pointer = 1;
  gp_base_in = 32'h0002_0000;
  gp_limit_in = 16'h03ff;
  tick;
  load_global_pointer = 0;
  chk(global_limit_r, 16'h03ff);
  mode = 2;
  paging_en = 0;
  stall = 3;
  ld(3, {13'h5, 1'b0, 2'h3}, 0, 1);
  chk(fa, 32'h0002_0028);
  xl(3, 32'h100, db(32'h0002_0028) + 32'h100, 3);
  chk(xl_most_priv, 0);
  chk(seg_kind_out, 2'h1);
  chk(seg_limit_out, 20'hfffff);
  chk(seg_attr_out, 8'h28);
  paging_en = 1;
  xl(3, 32'h4, db(32'h0002_0028) + 32'h4, 3);
  chk(desc_req, 0);
  ld(4, 16'h0000, 0, 0);
  xl(4, 32'h40, 32'h40, 0);
  chk(xl_null_fault, 1);
end
endtask
task t_local;
begin
  stall = 0;
  ld(0, {13'h2, 1'b0, 2'h0}, 1, 0);
  chk(fa, 32'h0002_0010);
  chk(local_base_r, db(32'h0002_0010));
  ld(5, {13'h3, 1'b1, 2'h1}, 0, 0);
  chk(fa, db(32'h0002_0010) + 32'h18);
  xl(5, 32'h4, db(db(32'h0002_0010) + 32'h18) + 32'h4, 1);
  chk(xl_null_fault, 0);
end
endtask
task t_store;
begin
  store_global_pointer = 1;
  tick;
  store_global_pointer = 0;
  chk(store_valid, 1);
  chk(store_data, {32'h0002_0000, 16'h03ff});
  store_local_selector = 1;
  tick;
  store_local_selector = 0;
  chk(store_data, {32'h0, 16'h0010});
  load_interrupt_table_pointer = 1;
  ip_base_in = 32'h0003_0000;
  ip_limit_in = 16'h07ff;
  tick;
  load_interrupt_table_pointer = 0;
  chk(int_base_r, 32'h0003_0000);
  chk(int_limit_r, 16'h07ff);
end
endtask
initial
begin
  repeat (8) @(posedge ref_clk);
  #10 nrst = 1;
  chk(global_limit_r, 16'hffff);
  chk(xl_most_priv, 1);
  t_real;
  t_prot;
  t_local;
  t_store;
  wrap_up;
end
endmodule
